// ==== design/sipc_pkg.sv ====
// constants shared by the sleep and idle power controller
package sipc_pkg;
    // power-save instruction operand: bit set selects full stop
    localparam logic MODE_FULL_STOP = 1'b1;
    localparam logic MODE_CORE_HALT = 1'b0;
    // new-oscillator select field inside the oscillator control register
    localparam int OSC_SEL_MSB = 10;
    localparam int OSC_SEL_LSB = 8;
    localparam int OSC_SEL_WIDTH = 3;
    localparam int OSC_CTRL_WIDTH = 16;
    localparam logic [2:0] OSC_SEL_RESET = 3'h0;
    // clocks counted by the settle counter after a wake; the core clock returns without waiting for it
    localparam int WAKE_SETTLE_CYCLES = 4;
    typedef enum logic [1:0] {ST_RUN, ST_CLEAR_WD, ST_STOP, ST_HALT} sipc_state_type;
endpackage

// ==== design/sipc_power_ctrl.sv ====
// sleep and idle power controller top level
// Function
// R1 - low power is entered only when the core issues the power-save instruction, operand picks the mode.
// R2 - full stop gates the system clock and halts all execution.
// R3 - core halt stops the cpu clock while peripherals keep their clock.
// R4 - either mode ends on an enabled interrupt, watchdog time-out or any reset.
// R5 - entering full stop shuts the clock source and turns off an on-chip oscillator.
// R6 - the low power rc clock runs through full stop while the watchdog is enabled.
// R7 - an enabled watchdog is cleared before full stop is entered.
// R8 - the fail-safe clock monitor is off throughout full stop.
// R9 - peripherals on the system clock are disabled in full stop.
// R10 - change detection and externally clocked peripherals stay able to wake the part.
// R11 - after full stop the same clock source resumes.
// R12 - an unlocked write of the new-oscillator select field requests a clock switch; the block accepts it only in run.
// R13 - a one-bit mode request is held until a wake condition occurs.
`timescale 1ns/1ps
module sipc_power_ctrl #(
    parameter int SETTLE = sipc_pkg::WAKE_SETTLE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic powerSaveInstruction,
    input wire logic powerSaveMode,
    input wire logic irqPending,
    input wire logic watchdogEnable,
    input wire logic watchdogTimeout,
    input wire logic deviceResetEvent,
    input wire logic onChipOscSelected,
    input wire logic clockConfigLocked,
    input wire logic oscCtrlWrite,
    input wire logic [15:0] oscCtrlWdata,
    output logic cpuClkEn_r,
    output logic periphClkEn_r,
    output logic sysClkEn_r,
    output logic onChipOscEn_r,
    output logic lowPowerRcClockEn_r,
    output logic watchdogClear_r,
    output logic failSafeMonEn_r,
    output logic wakeSourcesEn_r,
    output logic clockSwitchReq_r,
    output logic [2:0] newOscillatorSelect_r,
    output logic inSleep_r,
    output logic inIdle_r
);
    sipc_pkg::sipc_state_type state_r, state_nxt;
    logic [2:0] savedOscSel_r;
    logic wakeHit, settleDone;

    initial begin
        if (SETTLE < 1) begin
            $error("settle count must be at least one");
        end
        // the select field must sit inside the written control word
        if (sipc_pkg::OSC_SEL_MSB - sipc_pkg::OSC_SEL_LSB + 1 != sipc_pkg::OSC_SEL_WIDTH ||
            sipc_pkg::OSC_SEL_MSB >= sipc_pkg::OSC_CTRL_WIDTH) begin
            $error("oscillator select field does not fit the control word");
        end
    end

    // ****************************************
    // wake detection
    // ****************************************
    // wake inputs only count while a low-power state is held; in run they are ignored
    wire armed = (state_r == sipc_pkg::ST_STOP) || (state_r == sipc_pkg::ST_HALT);

    sipc_wake_detect #(.SETTLE(SETTLE)) wakeDet (
        .core_clk(core_clk),
        .rst(rst),
        .armed(armed),
        .irqPending(irqPending),
        .watchdogTimeout(watchdogTimeout),
        .resetEvent(deviceResetEvent),
        .wakeHit(wakeHit),
        .settleDone(settleDone)
    ); // R4

    // ****************************************
    // mode sequencing
    // ****************************************
    wire enterStop = powerSaveInstruction && (powerSaveMode == sipc_pkg::MODE_FULL_STOP); // R1
    wire enterHalt = powerSaveInstruction && (powerSaveMode == sipc_pkg::MODE_CORE_HALT); // R1
    wire oscSelWrite = oscCtrlWrite && !clockConfigLocked; // R12
    wire [2:0] oscSelField = oscCtrlWdata[sipc_pkg::OSC_SEL_MSB:sipc_pkg::OSC_SEL_LSB];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sipc_pkg::ST_RUN: begin
                if (enterStop) begin
                    state_nxt = sipc_pkg::ST_CLEAR_WD; // R7
                end else if (enterHalt) begin
                    state_nxt = sipc_pkg::ST_HALT; // R13
                end
            end
            // one prepare cycle lets the watchdog take its clear before the system and peripheral clocks are gated
            sipc_pkg::ST_CLEAR_WD: state_nxt = sipc_pkg::ST_STOP;
            sipc_pkg::ST_STOP, sipc_pkg::ST_HALT: begin
                if (wakeHit) begin
                    state_nxt = sipc_pkg::ST_RUN; // R4
                end
            end
            default: state_nxt = sipc_pkg::ST_RUN;
        endcase
    end

    wire nxtStop = (state_nxt == sipc_pkg::ST_STOP);
    wire nxtHalt = (state_nxt == sipc_pkg::ST_HALT);
    wire nxtClear = (state_nxt == sipc_pkg::ST_CLEAR_WD);
    // core stays gated from the prepare cycle on; no instruction may slip in
    wire nxtCoreOff = nxtStop || nxtHalt || nxtClear;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= sipc_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // clock gating outputs
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpuClkEn_r <= 1'b1;
            periphClkEn_r <= 1'b1;
            sysClkEn_r <= 1'b1;
            onChipOscEn_r <= 1'b1;
            lowPowerRcClockEn_r <= 1'b1;
            failSafeMonEn_r <= 1'b1;
            wakeSourcesEn_r <= 1'b1;
            inSleep_r <= 1'b0;
            inIdle_r <= 1'b0;
        end else begin
            cpuClkEn_r <= !nxtCoreOff; // R2 R3
            periphClkEn_r <= !nxtStop; // R3 R9
            sysClkEn_r <= !nxtStop; // R2 R5
            onChipOscEn_r <= !(nxtStop && onChipOscSelected); // R5
            lowPowerRcClockEn_r <= !nxtStop || watchdogEnable; // R6
            failSafeMonEn_r <= !nxtStop; // R8
            wakeSourcesEn_r <= 1'b1; // R10
            inSleep_r <= nxtStop;
            inIdle_r <= nxtHalt;
        end
    end

    // ****************************************
    // watchdog clear and oscillator select
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            watchdogClear_r <= 1'b0;
            clockSwitchReq_r <= 1'b0;
            newOscillatorSelect_r <= sipc_pkg::OSC_SEL_RESET;
            savedOscSel_r <= sipc_pkg::OSC_SEL_RESET;
        end else begin
            watchdogClear_r <= nxtClear && watchdogEnable; // R7
            clockSwitchReq_r <= oscSelWrite && (state_r == sipc_pkg::ST_RUN); // R12
            if (oscSelWrite && state_r == sipc_pkg::ST_RUN) begin
                newOscillatorSelect_r <= oscSelField; // R12
            end else if (state_r == sipc_pkg::ST_STOP && wakeHit) begin
                newOscillatorSelect_r <= savedOscSel_r; // R11
            end
            // writes are refused outside run, so the restore guards against a later bypass
            if (enterStop && state_r == sipc_pkg::ST_RUN) begin
                savedOscSel_r <= newOscillatorSelect_r; // R11
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    stop_gates_all_a: assert property (@(posedge core_clk) disable iff (rst) // R2
        inSleep_r |-> !sysClkEn_r && !periphClkEn_r && !cpuClkEn_r)
        else $error("full stop left a clock running");
    stop_prepared_a: assert property (@(posedge core_clk) disable iff (rst) // R2
        $rose(inSleep_r) |-> !$past(cpuClkEn_r))
        else $error("core ran in the cycle before full stop");
    halt_keeps_periph_a: assert property (@(posedge core_clk) disable iff (rst) // R3
        inIdle_r |-> periphClkEn_r && !cpuClkEn_r)
        else $error("core halt gated the wrong clock");
    idle_sys_on_a: assert property (@(posedge core_clk) disable iff (rst) // R3
        inIdle_r |-> sysClkEn_r && failSafeMonEn_r)
        else $error("core halt stopped the system clock");
    entry_needs_instr_a: assert property (@(posedge core_clk) disable iff (rst) // R1
        $rose(inIdle_r) |-> $past(powerSaveInstruction))
        else $error("low power entered without instruction");
    wake_exits_a: assert property (@(posedge core_clk) disable iff (rst) // R4
        (inSleep_r || inIdle_r) && (irqPending || watchdogTimeout || deviceResetEvent)
        |=> !inSleep_r && !inIdle_r && cpuClkEn_r)
        else $error("wake condition ignored");
    osc_off_stop_a: assert property (@(posedge core_clk) disable iff (rst) // R5
        inSleep_r && $past(onChipOscSelected) |-> !onChipOscEn_r)
        else $error("on-chip oscillator left on in full stop");
    rc_runs_wd_a: assert property (@(posedge core_clk) disable iff (rst) // R6
        $past(watchdogEnable) |-> lowPowerRcClockEn_r)
        else $error("rc clock stopped with watchdog on");
    wd_clear_first_a: assert property (@(posedge core_clk) disable iff (rst) // R7
        $rose(inSleep_r) && $past(watchdogEnable, 2) |-> $past(watchdogClear_r))
        else $error("watchdog not cleared before full stop");
    clear_one_pulse_a: assert property (@(posedge core_clk) disable iff (rst) // R7
        watchdogClear_r |=> !watchdogClear_r)
        else $error("watchdog clear held longer than one cycle");
    fsm_off_stop_a: assert property (@(posedge core_clk) disable iff (rst) // R8
        inSleep_r |-> !failSafeMonEn_r)
        else $error("clock monitor active in full stop");
    wake_src_kept_a: assert property (@(posedge core_clk) disable iff (rst) // R10
        inSleep_r |-> wakeSourcesEn_r)
        else $error("wake sources disabled in full stop");
    osc_resume_a: assert property (@(posedge core_clk) disable iff (rst) // R11
        $fell(inSleep_r) |-> newOscillatorSelect_r == savedOscSel_r)
        else $error("clock source changed across full stop");
    switch_req_a: assert property (@(posedge core_clk) disable iff (rst) // R12
        oscCtrlWrite && clockConfigLocked |=> !clockSwitchReq_r)
        else $error("locked clock configuration switched");
    switch_in_run_a: assert property (@(posedge core_clk) disable iff (rst) // R12
        inSleep_r || inIdle_r |=> !clockSwitchReq_r)
        else $error("clock switch requested in a low-power state");
    hold_mode_a: assert property (@(posedge core_clk) disable iff (rst) // R13
        inIdle_r && !(irqPending || watchdogTimeout || deviceResetEvent) |=> inIdle_r)
        else $error("mode dropped without wake");
    instr_ignored_a: assert property (@(posedge core_clk) disable iff (rst) // R13
        inIdle_r && powerSaveInstruction |=> !inSleep_r && !watchdogClear_r)
        else $error("instruction taken while halted");
endmodule

// ==== design/sipc_wake_detect.sv ====
// wake condition detector and settle counter
`timescale 1ns/1ps
module sipc_wake_detect #(
    parameter int SETTLE = sipc_pkg::WAKE_SETTLE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic armed,
    input wire logic irqPending,
    input wire logic watchdogTimeout,
    input wire logic resetEvent,
    output logic wakeHit,
    output logic settleDone
);
    localparam int CW = $clog2(SETTLE + 1);
    logic [CW-1:0] settleCnt_r;
    logic settling_r;
    wire anyWake = irqPending | watchdogTimeout | resetEvent;
    assign wakeHit = armed & anyWake;
    assign settleDone = settling_r && (settleCnt_r == CW'(SETTLE - 1));

    initial begin
        if (SETTLE < 1) begin
            $error("settle count must be at least one");
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            settling_r <= 1'b0;
            settleCnt_r <= '0;
        end else if (wakeHit) begin
            settling_r <= 1'b1;
            settleCnt_r <= '0;
        end else if (settleDone) begin
            settling_r <= 1'b0;
        end else if (settling_r) begin
            settleCnt_r <= settleCnt_r + CW'(1);
        end
    end
endmodule

// ==== tb/sipc_wdog_model.sv ====
// watchdog model that counts on the rc clock and wakes the controller
`timescale 1ns/1ps
module sipc_wdog_model #(
    parameter int LIMIT = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic watchdogEnable,
    input wire logic rcClkEn,
    input wire logic clearPulse,
    output logic watchdogTimeout
);
    // ****************************************
    // count
    // ****************************************
    int count_r;
    // counts only while the rc clock runs, so a gated rc clock means no wake
    always @(negedge core_clk or posedge rst) begin
        if (rst || clearPulse || !watchdogEnable) begin
            count_r <= 0;
        end else if (rcClkEn && count_r < LIMIT) begin
            count_r <= count_r + 1;
        end
    end
    assign watchdogTimeout = (count_r == LIMIT);
endmodule

// ==== tb/sleep_idle_power_control_tb_top.sv ====
// self-checking bench of the sleep and idle power controller
`timescale 1ns/1ps
module sleep_idle_power_control_tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic powerSaveInstruction = 1'b0, powerSaveMode = 1'b0, irqPending = 1'b0;
    logic watchdogEnable = 1'b0, deviceResetEvent = 1'b0, onChipOscSelected = 1'b0;
    logic clockConfigLocked = 1'b0, oscCtrlWrite = 1'b0;
    logic [15:0] oscCtrlWdata = 16'h0000;
    logic watchdogTimeout, cpuClkEn_r, periphClkEn_r, sysClkEn_r, onChipOscEn_r;
    logic lowPowerRcClockEn_r, watchdogClear_r, failSafeMonEn_r, wakeSourcesEn_r;
    logic clockSwitchReq_r, inSleep_r, inIdle_r;
    logic [2:0] newOscillatorSelect_r;
    int miscompares = 0;
    int n_checks = 0;
    wire logic [7:0] en = {cpuClkEn_r, periphClkEn_r, sysClkEn_r, onChipOscEn_r,
        lowPowerRcClockEn_r, failSafeMonEn_r, wakeSourcesEn_r, watchdogClear_r};
    wire logic [7:0] md = {6'h00, inSleep_r, inIdle_r};
    wire logic [7:0] osc = {4'h0, clockSwitchReq_r, newOscillatorSelect_r};

    sipc_power_ctrl dut_u (.core_clk, .rst, .powerSaveInstruction, .powerSaveMode,
        .irqPending, .watchdogEnable, .watchdogTimeout, .deviceResetEvent,
        .onChipOscSelected, .clockConfigLocked, .oscCtrlWrite, .oscCtrlWdata,
        .cpuClkEn_r, .periphClkEn_r, .sysClkEn_r, .onChipOscEn_r, .lowPowerRcClockEn_r,
        .watchdogClear_r, .failSafeMonEn_r, .wakeSourcesEn_r, .clockSwitchReq_r,
        .newOscillatorSelect_r, .inSleep_r, .inIdle_r);
    sipc_wdog_model wd_u (.core_clk, .rst, .watchdogEnable, .rcClkEn(lowPowerRcClockEn_r),
        .clearPulse(watchdogClear_r), .watchdogTimeout);

    always #12.5 core_clk = ~core_clk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic issue(input logic m);
        powerSaveInstruction = 1'b1;
        powerSaveMode = m;
        step(1);
        powerSaveInstruction = 1'b0;
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic run_idle;
        issue(sipc_pkg::MODE_CORE_HALT);
        chk(en, 8'h7e);
        chk(md, 8'h01);
        // a second instruction while halted must not turn idle into sleep
        step(1);
        issue(sipc_pkg::MODE_FULL_STOP);
        step(4);
        chk(md, 8'h01);
        irqPending = 1'b1;
        step(1);
        irqPending = 1'b0;
        chk(md, 8'h00);
        chk(en, 8'hfe);
    endtask
    task automatic run_sleep_wd;
        watchdogEnable = 1'b1;
        onChipOscSelected = 1'b1;
        step(10);
        issue(sipc_pkg::MODE_FULL_STOP);
        chk(en, 8'h7f);
        step(1);
        chk(en, 8'h0a);
        chk(md, 8'h02);
        // without the entry clear the count would already have expired here
        step(12);
        chk(md, 8'h02);
        step(6);
        chk(md, 8'h00);
        chk(en, 8'hfe);
        watchdogEnable = 1'b0;
        onChipOscSelected = 1'b0;
    endtask
    task automatic run_osc_sleep;
        clockConfigLocked = 1'b1;
        oscCtrlWrite = 1'b1;
        oscCtrlWdata = 16'h0300;
        step(1);
        chk(osc, 8'h00);
        clockConfigLocked = 1'b0;
        oscCtrlWdata = 16'h0500;
        step(1);
        oscCtrlWrite = 1'b0;
        chk(osc, 8'h0d);
        step(1);
        chk(osc, 8'h05);
        issue(sipc_pkg::MODE_FULL_STOP);
        step(1);
        chk(en, 8'h12);
        // an unlocked write in full stop must be refused and leave the source alone
        oscCtrlWrite = 1'b1;
        oscCtrlWdata = 16'h0200;
        step(1);
        oscCtrlWrite = 1'b0;
        chk(osc, 8'h05);
        deviceResetEvent = 1'b1;
        step(1);
        deviceResetEvent = 1'b0;
        chk(md, 8'h00);
        chk(osc, 8'h05);
    endtask
    task automatic run_reset_wake;
        // a reset in mid-run ends a low-power state and leaves the block usable
        step(1);
        issue(sipc_pkg::MODE_CORE_HALT);
        chk(md, 8'h01);
        rst = 1'b1;
        step(2);
        chk(md, 8'h00);
        chk(en, 8'hfe);
        chk(osc, 8'h00);
        rst = 1'b0;
        step(2);
        issue(sipc_pkg::MODE_FULL_STOP);
        step(1);
        chk(md, 8'h02);
        chk(en, 8'h12);
        irqPending = 1'b1;
        step(1);
        irqPending = 1'b0;
        chk(md, 8'h00);
        chk(en, 8'hfe);
    endtask

    initial begin
        step(16);
        chk(en, 8'hfe);
        rst = 1'b0;
        step(2);
        chk(md, 8'h00);
        run_idle();
        run_sleep_wd();
        run_osc_sleep();
        run_reset_wake();
        give_verdict();
    end
    initial begin
        #50000;
        miscompares++;
        give_verdict();
    end
endmodule
